//--- verilog/cc_unit_map.vh
// Register offsets, field positions and codes of the capture/compare unit
`ifndef CC_UNIT_MAP_VH
`define CC_UNIT_MAP_VH

// Word addresses of the scalar registers
`define CC_ADDR_CTRL       6'h00
`define CC_ADDR_CLKSEL     6'h01
`define CC_ADDR_T0_COUNT   6'h02
`define CC_ADDR_T0_RELOAD  6'h03
`define CC_ADDR_T1_COUNT   6'h04
`define CC_ADDR_T1_RELOAD  6'h05
`define CC_ADDR_STATUS     6'h06
`define CC_ADDR_MASK       6'h07
`define CC_ADDR_PINS       6'h08
// Address bits 5:4 pick a bank; bits 3:0 pick the channel
`define CC_BANK_SCALAR     2'h0
`define CC_BANK_MODE       2'h1
`define CC_BANK_VALUE      2'h2

// Control register fields
`define CC_CTRL_RUN0       0
`define CC_CTRL_RUN1       1
`define CC_CTRL_STAGGER    2
// Clock select: timer n uses bits 4n+2..4n
`define CC_CLKSEL_W        3
`define CC_CLKSEL_DIV8     3'h3
`define CC_CLKSEL_AUX      3'h4
`define CC_CLKSEL_EXT      3'h5
`define CC_STAGGER_LAST    3'h7

// Channel mode register fields
`define CC_MODE_W          6
`define CC_MODE_FN_LSB     0
`define CC_MODE_TSEL       3
`define CC_MODE_PAIRED     4
`define CC_MODE_ONESHOT    5
// Function codes
`define CC_FN_OFF          3'h0
`define CC_FN_CAP_RISE     3'h1
`define CC_FN_CAP_FALL     3'h2
`define CC_FN_CAP_BOTH     3'h3
`define CC_FN_CMP0         3'h4
`define CC_FN_CMP1         3'h5
`define CC_FN_CMP2         3'h6
`define CC_FN_CMP3         3'h7

// Reset value and timer top count
`define CC_RST_WORD        16'h0000
`define CC_TIMER_TOP       16'hffff

`endif

//--- verilog/cc_value_array.v
// Storage of the sixteen capture/compare values
`timescale 1ns/1ps
module cc_value_array #(
   parameter WIDTH = 16,
   parameter DEPTH = 16
) (
   // Clock and reset
   input  wire                   clock,
   input  wire                   rst_n,
   // Software write port
   input  wire [DEPTH-1:0]       bus_we,
   input  wire [WIDTH-1:0]       bus_wdata,
   // Capture write port, one word per entry
   input  wire [DEPTH-1:0]       cap_we,
   input  wire [WIDTH*DEPTH-1:0] cap_data,
   // All stored words, each straight from its register
   output wire [WIDTH*DEPTH-1:0] values
);

   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
         reg [WIDTH-1:0] word_q;
         // A capture beats a software write so no timer event is lost
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               word_q <= {WIDTH{1'b0}};
            end else if (cap_we[i]) begin
               word_q <= cap_data[i*WIDTH +: WIDTH];
            end else if (bus_we[i]) begin
               word_q <= bus_wdata;
            end
         end
         assign values[i*WIDTH +: WIDTH] = word_q;
      end
   endgenerate

endmodule

//--- verilog/cc_unit.v
// Sixteen channel capture/compare unit with two reloadable time bases
`timescale 1ns/1ps
`include "cc_unit_map.vh"

// Function
// - Sixteen channels, one cycle or eight staggered
// - Two 16-bit timers, each with reload
// - Timer clock: prescaler, auxiliary overflow, external input
// - Each channel picks timer and capture/compare
// - One pin per channel, input or output
// - Capture latches timer, raises channel request
// - Capture edge: rising, falling or both
// - Compare channels match continuously, then act
// - Mode 0: interrupt only, many per period
// - Mode 1: pin toggles on every match
// - Mode 2: interrupt only, once per period
// - Mode 3: set on match, clear on overflow
// - Paired registers share a pin, toggle it
// - One-shot option with any compare mode
module cc_unit #(
   parameter CHANNELS = 16,
   parameter TW       = 16,
   parameter AW       = 6
) (
   // Clock and reset
   input  wire                clock,
   input  wire                rst_n,
   // Register port
   input  wire [AW-1:0]       addr,
   input  wire [TW-1:0]       wr_data,
   input  wire                wr_en,
   input  wire                rd_en,
   output reg  [TW-1:0]       rd_data_q,
   // Count sources from outside
   input  wire                aux_timer_ovf,
   input  wire [1:0]          ext_count_in,
   // Channel pins
   input  wire [CHANNELS-1:0] cc_pin_in,
   output wire [CHANNELS-1:0] cc_pin_out,
   output wire [CHANNELS-1:0] cc_pin_oe,
   // Interrupt
   output reg                 irq_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode

   wire [1:0] bank = addr[5:4];
   wire [3:0] chan = addr[3:0];
   wire       wr_scalar = wr_en && (bank == `CC_BANK_SCALAR);
   wire       rd_status = rd_en && (addr == `CC_ADDR_STATUS);

   // Mode register width, needed by the flattened mode bus below
   localparam CC_MW = `CC_MODE_W;

   reg  [2:0]             ctrl_q;
   reg  [7:0]             clksel_q;
   reg  [TW-1:0]          mask_q;
   reg  [2:0]             stag_cnt_q;
   reg  [1:0]             ext_prev_q;
   reg  [CHANNELS-1:0]    pin_in_q;
   reg  [CHANNELS-1:0]    pin_prev_q;

   wire [2*TW-1:0]        cnt_flat;
   wire [2*TW-1:0]        reload_flat;
   wire [1:0]             tick_q_w;
   wire [1:0]             ovf_q_w;
   wire [CHANNELS-1:0]    cmp_evt;
   wire [CHANNELS-1:0]    paired;
   wire [CHANNELS-1:0]    status;
   wire [CHANNELS-1:0]    status_d;
   wire [CHANNELS-1:0]    cap_we;
   wire [TW*CHANNELS-1:0] cap_data;
   wire [TW*CHANNELS-1:0] values;
   wire [CHANNELS-1:0]    val_we;
   wire [CC_MW*CHANNELS-1:0] mode_flat;

   // Scalar control registers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q   <= 3'h0;
         clksel_q <= 8'h00;
         mask_q   <= `CC_RST_WORD;
      end else if (wr_scalar) begin
         if (addr == `CC_ADDR_CTRL) begin
            ctrl_q <= wr_data[2:0];
         end
         if (addr == `CC_ADDR_CLKSEL) begin
            clksel_q <= wr_data[7:0];
         end
         if (addr == `CC_ADDR_MASK) begin
            mask_q <= wr_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Resolution base and input sampling

   // Staggered operation gives the prescaler one step per eight cycles
   wire base_tick = !ctrl_q[`CC_CTRL_STAGGER] || (stag_cnt_q == `CC_STAGGER_LAST);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stag_cnt_q <= 3'h0;
         ext_prev_q <= 2'h0;
         pin_in_q   <= {CHANNELS{1'b0}};
         pin_prev_q <= {CHANNELS{1'b0}};
      end else begin
         stag_cnt_q <= stag_cnt_q + 3'h1;
         ext_prev_q <= ext_count_in;
         pin_in_q   <= cc_pin_in;
         pin_prev_q <= pin_in_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two time bases

   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1) begin : g_timer
         reg  [TW-1:0] cnt_q;
         reg  [TW-1:0] reload_q;
         reg  [2:0]    div_q;
         reg           tick_q;
         reg           ovf_q;
         wire [2:0]    sel = clksel_q[4*t +: 3];
         wire          run = ctrl_q[t];
         wire [2:0]    div_top = (3'h1 << sel[1:0]) - 3'h1;
         wire          wr_cnt = wr_scalar && (addr == `CC_ADDR_T0_COUNT + 2 * t);
         wire          wr_rel = wr_scalar && (addr == `CC_ADDR_T0_RELOAD + 2 * t);
         reg           src;

         // Count source selection
         always @* begin
            case (sel)
               3'h0, 3'h1, 3'h2, `CC_CLKSEL_DIV8: src = base_tick && (div_q == div_top);
               `CC_CLKSEL_AUX: src = aux_timer_ovf;
               `CC_CLKSEL_EXT: src = ext_count_in[t] && !ext_prev_q[t];
               default: src = 1'b0;
            endcase
         end

         // A stopped timer ignores its source, but the prescaler keeps turning
         wire tick = run && src;

         // Counter, prescaler and reload; a software write to the count wins
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               cnt_q    <= `CC_RST_WORD;
               reload_q <= `CC_RST_WORD;
               div_q    <= 3'h0;
               tick_q   <= 1'b0;
               ovf_q    <= 1'b0;
            end else begin
               if (wr_rel) begin
                  reload_q <= wr_data;
               end
               if (base_tick) begin
                  div_q <= (div_q >= div_top) ? 3'h0 : div_q + 3'h1;
               end
               // Tick and overflow are registered so compares see the stepped count;
               // a count write cancels both, so software never fakes an event
               tick_q <= tick && !wr_cnt;
               ovf_q  <= tick && !wr_cnt && (cnt_q == `CC_TIMER_TOP);
               if (wr_cnt) begin
                  cnt_q <= wr_data;
               end else if (tick) begin
                  if (cnt_q == `CC_TIMER_TOP) begin
                     cnt_q <= reload_q;
                  end else begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
            end
         end

         assign cnt_flat[t*TW +: TW]    = cnt_q;
         assign reload_flat[t*TW +: TW] = reload_q;
         assign tick_q_w[t]             = tick_q;
         assign ovf_q_w[t]              = ovf_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Channels

   genvar c;
   generate
      for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
         reg  [CC_MW-1:0] mode_q;
         reg              armed_q;
         reg              done_q;
         reg              pin_q;
         reg              oe_q;
         reg              flag_q;
         wire [2:0]       fn   = mode_q[2:0];
         wire             tsel = mode_q[`CC_MODE_TSEL];
         wire [TW-1:0]    tval = cnt_flat[tsel*TW +: TW];
         wire             is_cmp = fn[2];
         wire             rise = pin_in_q[c] && !pin_prev_q[c];
         wire             fall = !pin_in_q[c] && pin_prev_q[c];
         wire             wr_mode = wr_en && (bank == `CC_BANK_MODE) && (chan == c);
         wire             once = (fn == `CC_FN_CMP2) || (fn == `CC_FN_CMP3);
         // The upper channel of a pair gives its pin over to the lower one
         wire             given = (c >= CHANNELS / 2) && paired[c % (CHANNELS / 2)];
         wire             partner = (c < CHANNELS / 2) && paired[c]
                                    && cmp_evt[(c + CHANNELS / 2) % CHANNELS];
         wire             drive = !given && is_cmp
                                  && ((fn == `CC_FN_CMP1) || (fn == `CC_FN_CMP3) || paired[c]);

         // Capture edge choice
         wire cap_evt = ((fn == `CC_FN_CAP_RISE) && rise)
                     || ((fn == `CC_FN_CAP_FALL) && fall)
                     || ((fn == `CC_FN_CAP_BOTH) && (rise || fall));

         // A match counts only on the cycle after the timer steps, so a stopped
         // timer that rests on the compare value does not repeat the event
         wire match = is_cmp && tick_q_w[tsel] && (tval == values[c*TW +: TW]);
         assign cmp_evt[c] = match && !done_q && (!once || armed_q);

         // Mode, period arming and one-shot state
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               mode_q  <= 6'h00;
               armed_q <= 1'b1;
               done_q  <= 1'b0;
            end else if (wr_mode) begin
               mode_q  <= wr_data[CC_MW-1:0];
               armed_q <= 1'b1;
               done_q  <= 1'b0;
            end else begin
               if (ovf_q_w[tsel]) begin
                  armed_q <= 1'b1;
               end else if (cmp_evt[c]) begin
                  armed_q <= 1'b0;
               end
               if (cmp_evt[c] && mode_q[`CC_MODE_ONESHOT]) begin
                  done_q <= 1'b1;
               end
            end
         end

         // Pin action; in mode 0 and mode 2 the pin is left alone unless the channel is paired
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               pin_q <= 1'b0;
               oe_q  <= 1'b0;
            end else begin
               oe_q <= drive;
               if (!given && (((fn == `CC_FN_CMP1) || paired[c]) && cmp_evt[c] || partner)) begin
                  pin_q <= !pin_q;
               end else if (!given && (fn == `CC_FN_CMP3) && cmp_evt[c]) begin
                  pin_q <= 1'b1;
               end else if (!given && (fn == `CC_FN_CMP3) && ovf_q_w[tsel]) begin
                  pin_q <= 1'b0;
               end
            end
         end

         // Sticky request; a new event in the clearing read cycle survives
         assign status_d[c] = cap_evt || cmp_evt[c] || (flag_q && !rd_status);
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               flag_q <= 1'b0;
            end else begin
               flag_q <= status_d[c];
            end
         end

         assign paired[c]                  = is_cmp && mode_q[`CC_MODE_PAIRED] && (c < CHANNELS / 2);
         assign status[c]                  = flag_q;
         assign cap_we[c]                  = cap_evt;
         assign cap_data[c*TW +: TW]       = tval;
         assign val_we[c]                  = wr_en && (bank == `CC_BANK_VALUE) && (chan == c);
         assign mode_flat[c*CC_MW +: CC_MW] = mode_q;
         assign cc_pin_out[c]              = pin_q;
         assign cc_pin_oe[c]               = oe_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Value storage

   cc_value_array #(
      .WIDTH (TW),
      .DEPTH (CHANNELS)
   ) u_values (
      .clock     (clock),
      .rst_n     (rst_n),
      .bus_we    (val_we),
      .bus_wdata (wr_data),
      .cap_we    (cap_we),
      .cap_data  (cap_data),
      .values    (values)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read data and interrupt

   reg [TW-1:0] rd_mux;

   // Reads of unmapped words return zero
   always @* begin
      rd_mux = `CC_RST_WORD;
      case (bank)
         `CC_BANK_SCALAR: begin
            case (addr)
               `CC_ADDR_CTRL:      rd_mux = {13'h0000, ctrl_q};
               `CC_ADDR_CLKSEL:    rd_mux = {8'h00, clksel_q};
               `CC_ADDR_T0_COUNT:  rd_mux = cnt_flat[TW-1:0];
               `CC_ADDR_T0_RELOAD: rd_mux = reload_flat[TW-1:0];
               `CC_ADDR_T1_COUNT:  rd_mux = cnt_flat[2*TW-1:TW];
               `CC_ADDR_T1_RELOAD: rd_mux = reload_flat[2*TW-1:TW];
               `CC_ADDR_STATUS:    rd_mux = status;
               `CC_ADDR_MASK:      rd_mux = mask_q;
               `CC_ADDR_PINS:      rd_mux = pin_in_q;
               default:            rd_mux = `CC_RST_WORD;
            endcase
         end
         `CC_BANK_MODE:  rd_mux = {10'h000, mode_flat[chan*CC_MW +: CC_MW]};
         `CC_BANK_VALUE: rd_mux = values[chan*TW +: TW];
         default:        rd_mux = `CC_RST_WORD;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= `CC_RST_WORD;
         irq_q     <= 1'b0;
      end else begin
         rd_data_q <= rd_en ? rd_mux : `CC_RST_WORD;
         // The mask comes from its register, so a mask write shows one cycle later
         irq_q     <= |(status_d & mask_q);
      end
   end

endmodule

//--- sim/cc_unit_checker.sv
// Port assertions of the capture/compare unit and their bind
`timescale 1ns/1ps
`include "cc_unit_map.vh"
module cc_unit_checker #(
   parameter CHANNELS = 16,
   parameter TW       = 16,
   parameter AW       = 6
) (
   // Clock and reset
   input wire                clock,
   input wire                rst_n,
   // Register port
   input wire [AW-1:0]       addr,
   input wire [TW-1:0]       wr_data,
   input wire                wr_en,
   input wire                rd_en,
   input wire [TW-1:0]       rd_data_q,
   // Pins and interrupt
   input wire [CHANNELS-1:0] cc_pin_in,
   input wire [CHANNELS-1:0] cc_pin_oe,
   input wire                irq_q
);
   reg        mask_zero_q;
   reg  [2:0] ctrl_q;
   // Decoded accesses; only a mode write may move an enable
   wire       wr_mode = wr_en && addr[5:4] == `CC_BANK_MODE;
   wire       clr_irq = (rd_en && addr == `CC_ADDR_STATUS) || (wr_en && addr == `CC_ADDR_MASK);
   wire       rd_void = rd_en && (addr[5:4] == 2'h3 || (addr[5:4] == 2'h0 && addr[3:0] > 4'h8));
   ////////////////////////////////////////
   // Shadows of the last mask and control writes
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_zero_q <= 1'b1;
         ctrl_q      <= 3'h0;
      end else if (wr_en && addr == `CC_ADDR_MASK) begin
         mask_zero_q <= wr_data == 16'h0000;
      end else if (wr_en && addr == `CC_ADDR_CTRL) begin
         ctrl_q <= wr_data[2:0];
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Pin read whose inputs held still, so either sampling stage gives one answer
   sequence s_pins_read;
      rd_en && addr == `CC_ADDR_PINS && $stable(cc_pin_in);
   endsequence
   a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data_q == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property ($past(rd_void) |-> rd_data_q == 16'h0000)
      else $error("unmapped read not zero");
   a_pins_read_back: assert property (s_pins_read |=> rd_data_q == $past(cc_pin_in, 2))
      else $error("pin level read wrong");
   a_mode_read_width: assert property ($past(rd_en && addr[5:4] == `CC_BANK_MODE)
      |-> rd_data_q[TW-1:`CC_MODE_W] == '0) else $error("mode read too wide");
   a_ctrl_read_back: assert property ($past(rd_en && addr == `CC_ADDR_CTRL)
      |-> rd_data_q[2:0] == ctrl_q) else $error("control read differs from write");
   a_irq_masked_off: assert property (mask_zero_q && $past(mask_zero_q) |-> !irq_q)
      else $error("interrupt with all sources masked");
   a_irq_fall_cause: assert property ($fell(irq_q) |-> $past(clr_irq) || $past(clr_irq, 2))
      else $error("interrupt dropped without clear");
   a_oe_needs_mode: assert property (cc_pin_oe != $past(cc_pin_oe)
      |-> $past(wr_mode) || $past(wr_mode, 2)) else $error("pin enable moved alone");
endmodule
bind cc_unit cc_unit_checker #(.CHANNELS(CHANNELS), .TW(TW), .AW(AW)) u_cc_unit_checker (
   .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data_q(rd_data_q), .cc_pin_in(cc_pin_in), .cc_pin_oe(cc_pin_oe),
   .irq_q(irq_q));

//--- sim/cc_pin_model.sv
// Far-side model of the channel pins
`timescale 1ns/1ps
module cc_pin_model (
   // Levels from the unit
   input  wire [15:0] cc_pin_out,
   input  wire [15:0] cc_pin_oe,
   // Level the outside world puts on pins the unit releases
   input  wire [15:0] drive,
   // Resolved levels back into the unit
   output wire [15:0] cc_pin_in
);
   // A driven pin shows the unit's level, a released one the external source
   assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drive);
endmodule

//--- sim/cc_unit_tb.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`include "cc_unit_map.vh"
module cc_unit_tb;
   reg         clock = 1'b0;
   reg         rst_n = 1'b0;
   reg  [5:0]  addr = 6'h00;
   reg  [15:0] wr_data = 16'h0000;
   reg         wr_en = 1'b0;
   reg         rd_en = 1'b0;
   reg         aux = 1'b0;
   reg  [1:0]  ext = 2'h0;
   reg  [15:0] drive = 16'h0000;
   reg  [15:0] mask_v = 16'h0000;
   reg  [15:0] d;
   reg  [15:0] e;
   reg  [15:0] i;
   reg         p;
   wire [15:0] rd_data_q;
   wire [15:0] pin_in;
   wire [15:0] pin_out;
   wire [15:0] pin_oe;
   wire        irq_q;
   integer     n_fail = 0;
   integer     n_compared = 0;
   // 40 MHz clock
   always #12.5 clock = ~clock;
   cc_unit DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .aux_timer_ovf(aux),
      .ext_count_in(ext), .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe(pin_oe),
      .irq_q(irq_q));
   cc_pin_model u_pins (.cc_pin_out(pin_out), .cc_pin_oe(pin_oe), .drive(drive),
      .cc_pin_in(pin_in));
   ////////////////////////////////////////
   task report_and_stop;
      begin
         if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %0s: expected %h, seen %h", what, exp, got);
         end
      end
   endtask
   // Bus cycles: one-cycle strobes, a gap edge between calls keeps drivers single
   task wr(input [5:0] a, input [15:0] v);
      begin
         @(posedge clock);
         addr    <= a;
         wr_data <= v;
         wr_en   <= 1'b1;
         @(posedge clock);
         wr_en   <= 1'b0;
      end
   endtask
   task rc(input [5:0] a, input [15:0] exp, input [63:0] what);
      begin
         @(posedge clock);
         addr  <= a;
         rd_en <= 1'b1;
         @(posedge clock);
         rd_en <= 1'b0;
         #1 d = rd_data_q;
         chk(what, exp, d);
      end
   endtask
   // One count pulse on the auxiliary overflow or both external inputs
   task tick(input sel);
      begin
         @(posedge clock);
         aux <= !sel;
         ext <= {2{sel}};
         @(posedge clock);
         aux <= 1'b0;
         ext <= 2'h0;
      end
   endtask
   task step(input [15:0] start, input integer n);
      begin
         wr(`CC_ADDR_T0_COUNT, start);
         repeat (n) tick(1'b0);
         repeat (3) @(posedge clock);
      end
   endtask
   // Interrupt level, pin level, flags, then the level after clearing
   task ev(input [15:0] st, input [15:0] pins);
      begin
         #1;
         chk("irq", {15'h0000, |(st & mask_v)}, {15'h0000, irq_q});
         chk("pin", pins, pin_out & 16'h0004);
         rc(`CC_ADDR_STATUS, st, "status");
         repeat (2) @(posedge clock);
         #1;
         chk("irq", 16'h0000, {15'h0000, irq_q});
      end
   endtask
   ////////////////////////////////////////
   // Watchdog far beyond the several hundred cycles of the tests
   initial begin
      #(25 * 20000);
      n_fail = n_fail + 1;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 0; i < 9; i = i + 1)
         rc(i[5:0], 16'h0000, "reset");
      wr(6'h30, 16'hffff);
      rc(6'h30, 16'h0000, "unmapped");
      wr(6'h15, 16'h001b);
      rc(6'h15, 16'h001b, "mode");
      wr(6'h15, 16'h0000);
      // Reload at the top, auxiliary and external counting
      wr(`CC_ADDR_CLKSEL, 16'h0054);
      wr(`CC_ADDR_T0_COUNT, 16'hfffe);
      wr(`CC_ADDR_T0_RELOAD, 16'h1234);
      wr(`CC_ADDR_CTRL, 16'h0003);
      repeat (3) tick(1'b0);
      repeat (2) tick(1'b1);
      rc(`CC_ADDR_T0_COUNT, 16'h1235, "t0");
      rc(`CC_ADDR_T1_COUNT, 16'h0002, "t1");
      // Any 64-cycle run gives 64 ticks, or 8 when staggered or divided by eight
      wr(`CC_ADDR_CTRL, 16'h0000);
      for (i = 0; i < 3; i = i + 1) begin
         wr(`CC_ADDR_CLKSEL, i[1] ? 16'h0034 : 16'h0004);
         wr(`CC_ADDR_T1_COUNT, 16'h0000);
         wr(`CC_ADDR_CTRL, i[0] ? 16'h0006 : 16'h0002);
         repeat (62) @(posedge clock);
         wr(`CC_ADDR_CTRL, 16'h0000);
         rc(`CC_ADDR_T1_COUNT, i == 0 ? 16'h0040 : 16'h0008, "tick");
      end
      // Capture on rise, fall and both, from either timer
      for (i = 1; i < 4; i = i + 1) begin
         wr(`CC_ADDR_T0_COUNT, 16'h1000 + i);
         wr(`CC_ADDR_T1_COUNT, 16'h2000 + i);
         wr(6'h18 + i[5:0], i == 2 ? 16'h000a : i);
         e = i == 2 ? 16'h2002 : 16'h1000 + i;
         @(posedge clock);
         drive[8+i] <= 1'b1;
         repeat (4) @(posedge clock);
         rc(`CC_ADDR_PINS, 16'h0001 << (8 + i), "pins");
         rc(6'h28 + i[5:0], i == 2 ? 16'h0000 : e, "capture");
         rc(`CC_ADDR_STATUS, i == 2 ? 16'h0000 : 16'h0001 << (8 + i), "status");
         @(posedge clock);
         drive[8+i] <= 1'b0;
         repeat (4) @(posedge clock);
         rc(6'h28 + i[5:0], e, "capture");
         rc(`CC_ADDR_STATUS, i == 1 ? 16'h0000 : 16'h0001 << (8 + i), "status");
      end
      // Compare on channel 2, timer 0 stepped by auxiliary pulses
      wr(6'h22, 16'h0005);
      wr(`CC_ADDR_T0_RELOAD, 16'h0004);
      wr(`CC_ADDR_CTRL, 16'h0001);
      wr(6'h12, 16'h0004);
      step(16'h0003, 2);
      ev(16'h0004, 16'h0000);
      chk("oe", 16'h0000, pin_oe & 16'h0004);
      mask_v = 16'h0004;
      wr(`CC_ADDR_MASK, mask_v);
      step(16'h0003, 2);
      ev(16'h0004, 16'h0000);
      wr(6'h12, 16'h0005);
      step(16'h0003, 2);
      ev(16'h0004, 16'h0004);
      chk("oe", 16'h0004, pin_oe & 16'h0004);
      step(16'h0003, 2);
      ev(16'h0004, 16'h0000);
      wr(6'h12, 16'h0006);
      step(16'hfffe, 3);
      ev(16'h0004, 16'h0000);
      step(16'h0003, 2);
      ev(16'h0000, 16'h0000);
      step(16'hfffe, 3);
      ev(16'h0004, 16'h0000);
      wr(6'h12, 16'h0007);
      step(16'hfffe, 3);
      ev(16'h0004, 16'h0004);
      step(16'hfffe, 2);
      ev(16'h0000, 16'h0000);
      // Single event, then two registers on one pin
      wr(6'h12, 16'h0025);
      #1;
      p = pin_out[2];
      step(16'h0003, 2);
      ev(16'h0004, {13'h0000, ~p, 2'h0});
      step(16'h0003, 2);
      ev(16'h0000, {13'h0000, ~p, 2'h0});
      wr(6'h2a, 16'h0007);
      wr(6'h1a, 16'h0005);
      wr(6'h12, 16'h0015);
      #1;
      p = pin_out[2];
      step(16'h0003, 2);
      ev(16'h0004, {13'h0000, ~p, 2'h0});
      step(16'h0006, 1);
      ev(16'h0400, {13'h0000, p, 2'h0});
      chk("oe", 16'h0004, pin_oe & 16'h0404);
      report_and_stop;
   end
endmodule
